// *** core/bank_addr_top.sv ***
// Direct address generation for the banked data memory, with a bus slave.
`timescale 1ns/1ps
`default_nettype none

module bank_addr_top
#(
  parameter logic [15:0] IMPL_MASK = 16'hffff
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic op_valid,
  input wire logic [1:0] op_kind,
  input wire logic [7:0] op_faddr,
  input wire logic op_access,
  input wire logic [7:0] op_wdata,
  input wire logic [7:0] op_literal,
  input wire logic [11:0] op_src,
  input wire logic [11:0] op_dst,
  output logic op_ready,
  output logic op_done,
  output logic [7:0] op_rdata,
  output logic flag_zero,
  output logic flag_neg,
  output logic high_area_hit,
  output logic bank_missing
);

  // ==========================================================
  // State
  logic [7:0] bank_sel_q;
  logic [7:0] bank_sel_d;
  bank_addr_pkg::seq_state_t state_q;
  bank_addr_pkg::seq_state_t state_d;
  logic [11:0] dst_q;
  logic [7:0] move_data_q;
  logic done_q;
  logic [7:0] rdata_q;
  logic zero_q;
  logic neg_q;
  logic high_q;
  logic miss_q;
  logic [11:0] last_addr_q;
  logic bus_wr_q;
  logic [7:0] bus_addr_q;
  logic [31:0] hrdata_q;

  ram_port_if rp();

  bank_ram
  #(
    .BANKS(bank_addr_pkg::BANK_COUNT)
  )
  u_ram
  (
    .clk(hclk),
    .port(rp.mem)
  );

  // ==========================================================
  // Operation decode
  logic op_fire;
  logic is_read;
  logic is_write;
  logic is_load;
  logic is_move;
  logic in_low;
  logic [11:0] win_addr;
  logic [11:0] bank_addr;
  logic [11:0] direct_addr;
  logic [11:0] mem_addr;
  logic impl_w;
  logic mem_we;
  logic [7:0] mem_rd;

  assign op_ready = (state_q == bank_addr_pkg::ST_IDLE);
  assign op_fire = op_valid && op_ready;
  assign is_read = op_fire && (op_kind == 2'(bank_addr_pkg::OP_READ));
  assign is_write = op_fire && (op_kind == 2'(bank_addr_pkg::OP_WRITE));
  assign is_load = op_fire && (op_kind == 2'(bank_addr_pkg::OP_LOAD_BANK));
  assign is_move = op_fire && (op_kind == 2'(bank_addr_pkg::OP_MOVE));

  // The low window part ends at 5Fh and 60h continues in bank 15, so the
  // window is one unbroken run of 256 file addresses.
  assign in_low = (op_faddr < bank_addr_pkg::ACC_SPLIT);
  assign win_addr = in_low ? {bank_addr_pkg::LOW_BANK, op_faddr}
                           : {bank_addr_pkg::HIGH_BANK, op_faddr};
  assign bank_addr = {bank_sel_q[3:0], op_faddr};
  assign direct_addr = op_access ? bank_addr : win_addr;

  // A move reads its source on acceptance and writes its target next cycle.
  assign mem_addr = (state_q == bank_addr_pkg::ST_MOVE_WR) ? dst_q
                  : (is_move ? op_src : direct_addr);
  assign impl_w = IMPL_MASK[mem_addr[11:8]];
  assign mem_we = impl_w && (is_write ||
                  (state_q == bank_addr_pkg::ST_MOVE_WR));
  assign mem_rd = impl_w ? rp.rdata : 8'h00;

  assign rp.we = mem_we;
  assign rp.addr = mem_addr;
  assign rp.wdata = (state_q == bank_addr_pkg::ST_MOVE_WR) ? move_data_q
                                                          : op_wdata;

  // ==========================================================
  // Sequencer
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      bank_addr_pkg::ST_IDLE:
      begin
        if (is_move)
        begin
          state_d = bank_addr_pkg::ST_MOVE_WR;
        end
      end
      bank_addr_pkg::ST_MOVE_WR:
      begin
        state_d = bank_addr_pkg::ST_IDLE;
      end
      default:
      begin
        state_d = bank_addr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= bank_addr_pkg::ST_IDLE;
      dst_q <= 12'h000;
      move_data_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      if (is_move)
      begin
        dst_q <= op_dst;
        move_data_q <= mem_rd;
      end
    end
  end

  // ==========================================================
  // Results and flags
  // Flags come from the byte the operation handles: the read byte for a
  // read, the written byte for a write, even when the bank is absent.
  logic [7:0] flag_src;
  logic flag_upd;
  logic done_d;

  assign flag_src = is_read ? mem_rd : op_wdata;
  assign flag_upd = is_read || is_write;
  assign done_d = is_read || is_write || is_load ||
                  (state_q == bank_addr_pkg::ST_MOVE_WR);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      done_q <= 1'b0;
      rdata_q <= 8'h00;
      zero_q <= 1'b0;
      neg_q <= 1'b0;
    end
    else
    begin
      done_q <= done_d;
      if (is_read)
      begin
        rdata_q <= mem_rd;
      end
      if (flag_upd)
      begin
        zero_q <= (flag_src == 8'h00);
        neg_q <= flag_src[7];
      end
    end
  end

  // Where the last RAM access landed, for the pins and the status word.
  logic touch_w;
  assign touch_w = is_read || is_write || is_move ||
                   (state_q == bank_addr_pkg::ST_MOVE_WR);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      high_q <= 1'b0;
      miss_q <= 1'b0;
      last_addr_q <= 12'h000;
    end
    else if (touch_w)
    begin
      high_q <= (mem_addr[11:8] == bank_addr_pkg::HIGH_BANK) &&
               (mem_addr[7:0] >= bank_addr_pkg::ACC_SPLIT);
      miss_q <= !impl_w;
      last_addr_q <= mem_addr;
    end
  end

  assign op_done = done_q;
  assign op_rdata = rdata_q;
  assign flag_zero = zero_q;
  assign flag_neg = neg_q;
  assign high_area_hit = high_q;
  assign bank_missing = miss_q;

  // ==========================================================
  // Bank select register
  // A load-bank-literal in the same cycle as a bus write wins, since the
  // instruction stream must see the bank it asked for.
  logic bus_bank_wr;
  assign bus_bank_wr = bus_wr_q && (bus_addr_q == bank_addr_pkg::BANK_SEL_OFF);

  always_comb
  begin
    bank_sel_d = bank_sel_q;
    if (is_load)
    begin
      bank_sel_d = {4'h0, op_literal[3:0]};
    end
    else if (bus_bank_wr)
    begin
      bank_sel_d = {4'h0, hwdata[3:0]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bank_sel_q <= bank_addr_pkg::BANK_SEL_RST;
    end
    else
    begin
      bank_sel_q <= bank_sel_d;
    end
  end

  // ==========================================================
  // AHB-Lite slave, zero wait states
  logic bus_take;
  logic [31:0] status_w;
  logic [31:0] rd_sel;

  assign bus_take = hsel && hready && htrans[1];
  assign status_w = {17'h0, !op_ready, high_q, miss_q, last_addr_q};

  always_comb
  begin
    rd_sel = 32'h0;
    if (haddr[7:0] == bank_addr_pkg::BANK_SEL_OFF)
    begin
      rd_sel = {24'h0, bank_sel_q};
    end
    else if (haddr[7:0] == bank_addr_pkg::STATUS_OFF)
    begin
      rd_sel = status_w;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_wr_q <= 1'b0;
      bus_addr_q <= 8'h00;
      hrdata_q <= 32'h0;
    end
    else
    begin
      bus_wr_q <= bus_take && hwrite;
      if (bus_take)
      begin
        bus_addr_q <= haddr[7:0];
        hrdata_q <= hwrite ? 32'h0 : rd_sel;
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  bank_hi_zero_a: assert property (bank_sel_q[7:4] == 4'h0)
    else $error("bank select upper bits not zero");

  win_low_map_a: assert property (
    (is_read || is_write) && !op_access && op_faddr < 8'h60
    |-> mem_addr == {4'h0, op_faddr})
    else $error("low window address not in bank 0");

  win_high_map_a: assert property (
    (is_read || is_write) && !op_access && op_faddr >= 8'h60
    |-> mem_addr == {4'hf, op_faddr})
    else $error("high window address not in bank 15");

  banked_addr_a: assert property (
    (is_read || is_write) && op_access
    |-> mem_addr == {bank_sel_q[3:0], op_faddr})
    else $error("banked address does not use bank select");

  miss_read_a: assert property (
    is_read && !IMPL_MASK[mem_addr[11:8]]
    |=> op_rdata == 8'h00 && bank_missing)
    else $error("absent bank read not zero");

  miss_write_a: assert property (
    !IMPL_MASK[mem_addr[11:8]] |-> !rp.we)
    else $error("write reached an absent bank");

  miss_flags_a: assert property (
    is_write |=> op_done && flag_zero == ($past(op_wdata) == 8'h00))
    else $error("flags not updated by write");

  move_addr_a: assert property (
    is_move |-> mem_addr == op_src ##1 mem_addr == $past(op_dst)
    ##1 op_done && op_ready)
    else $error("move did not use full addresses");

  load_bank_a: assert property (
    is_load |=> bank_sel_q == {4'h0, $past(op_literal[3:0])})
    else $error("load bank literal not applied");

  high_window_a: assert property (
    (is_read || is_write) && !op_access && op_faddr >= 8'h60
    |=> high_area_hit)
    else $error("high window not flagged as register area");

  window_read_c: cover property (is_read && !op_access);
  banked_write_c: cover property (is_write && op_access);
  move_done_c: cover property (is_move ##2 op_done);
  bus_bank_c: cover property (bus_bank_wr);

endmodule

`default_nettype wire

// *** include/bank_addr_pkg.sv ***
// Constants and types shared by the banked data memory addressing block.
package bank_addr_pkg;

  // ==========================================================
  // Memory geometry
  localparam int BANK_COUNT = 16;
  localparam int BANK_BYTES = 256;
  localparam int ACC_LOW_BYTES = 96;
  localparam int ACC_HIGH_BYTES = 160;
  localparam logic [7:0] ACC_SPLIT = 8'h60;
  localparam logic [3:0] LOW_BANK = 4'h0;
  localparam logic [3:0] HIGH_BANK = 4'hf;

  // ==========================================================
  // Register map, byte addresses on the bus
  localparam logic [7:0] BANK_SEL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] BANK_SEL_RST = 8'h00;
  localparam int ST_ADDR_LSB = 0;
  localparam int ST_MISS_BIT = 12;
  localparam int ST_HIGH_BIT = 13;
  localparam int ST_BUSY_BIT = 14;

  // ==========================================================
  // Decoder operations and sequencer states
  typedef enum logic [1:0]
  {
    OP_READ,
    OP_WRITE,
    OP_LOAD_BANK,
    OP_MOVE
  } op_kind_t;

  typedef enum logic
  {
    ST_IDLE,
    ST_MOVE_WR
  } seq_state_t;

endpackage

// *** include/ram_port_if.sv ***
// Port between the addressing logic and the static data RAM.
`timescale 1ns/1ps
`default_nettype none

interface ram_port_if;
  logic we;
  logic [11:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport ctrl
  (
    output we,
    output addr,
    output wdata,
    input rdata
  );

  modport mem
  (
    input we,
    input addr,
    input wdata,
    output rdata
  );
endinterface

`default_nettype wire

// *** core/bank_ram.sv ***
// Static data RAM of byte cells, read combinationally, written on the clock.
`timescale 1ns/1ps
`default_nettype none

module bank_ram
#(
  parameter int BANKS = 16
)
(
  input wire logic clk,
  ram_port_if.mem port
);

  // ==========================================================
  // Storage
  // Cells are never reset: the RAM keeps no defined power-up value.
  logic [7:0] mem_q [BANKS*bank_addr_pkg::BANK_BYTES];
  logic [7:0] rd_w;

  always_ff @(posedge clk)
  begin
    if (port.we)
    begin
      mem_q[port.addr] <= port.wdata;
    end
  end

  // The caller never presents an address beyond BANKS banks.
  assign rd_w = mem_q[port.addr];
  assign port.rdata = rd_w;

endmodule

`default_nettype wire

// *** verification/op_decoder.sv ***
// Instruction decoder model that issues data memory operations.
`timescale 1ns/1ps
`default_nettype none

module op_decoder
(
  input wire logic hclk,
  input wire logic op_ready,
  input wire logic op_done,
  output logic op_valid,
  output logic [1:0] op_kind,
  output logic [7:0] op_faddr,
  output logic op_access,
  output logic [7:0] op_wdata,
  output logic [7:0] op_literal,
  output logic [11:0] op_src,
  output logic [11:0] op_dst
);
  initial
  begin
    op_valid = 1'b0;
    op_kind = 2'h0;
    op_faddr = 8'h00;
    op_access = 1'b0;
    op_wdata = 8'h00;
    op_literal = 8'h00;
    op_src = 12'h000;
    op_dst = 12'h000;
  end

  // ==========================================================
  // Request, hold until taken, then wait for completion
  task automatic issue(input logic [1:0] k, input logic a, input logic [7:0] f,
    input logic [7:0] d, input logic [11:0] s, input logic [11:0] t,
    output logic ok);
    int n;
    n = 0;
    repeat ($urandom % 2) @(posedge hclk);
    op_valid <= 1'b1;
    op_kind <= k;
    op_access <= a;
    op_faddr <= f;
    op_wdata <= d;
    op_literal <= d;
    op_src <= s;
    op_dst <= t;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (op_ready !== 1'b1 && n < 20);
    // Released op_faddr, op_wdata, op_src and op_dst flip so a stale value cannot look valid; op_literal is held.
    op_valid <= 1'b0;
    op_faddr <= ~f;
    op_wdata <= ~d;
    op_src <= ~s;
    op_dst <= ~t;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (op_done !== 1'b1 && n < 20);
    ok = (n < 20);
  endtask
endmodule

`default_nettype wire

// *** verification/data_memory_bank_addressing_tb.sv ***
// Self-checking bench for the banked data memory addressing block.
`timescale 1ns/1ps
`default_nettype none

module data_memory_bank_addressing_tb;
  // Bank 14 is left out to exercise the absent-bank path.
  localparam logic [15:0] MASK = 16'hbfff;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, op_valid, op_access, op_ready, op_done;
  logic flag_zero, flag_neg, high_area_hit, bank_missing;
  logic [1:0] op_kind;
  logic [7:0] op_faddr, op_wdata, op_literal, op_rdata, f;
  logic [11:0] op_src, op_dst, s, t;
  logic [31:0] hrdata, rd;
  logic [3:0] bs;
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;
  int mem[int];

  always #12.5 hclk = ~hclk;

  bank_addr_top #(.IMPL_MASK(MASK)) i_bank_addr_top (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .op_valid(op_valid), .op_kind(op_kind), .op_faddr(op_faddr),
    .op_access(op_access), .op_wdata(op_wdata), .op_literal(op_literal),
    .op_src(op_src), .op_dst(op_dst), .op_ready(op_ready),
    .op_done(op_done), .op_rdata(op_rdata), .flag_zero(flag_zero),
    .flag_neg(flag_neg), .high_area_hit(high_area_hit),
    .bank_missing(bank_missing));

  op_decoder i_op_decoder (.hclk(hclk), .op_ready(op_ready),
    .op_done(op_done), .op_valid(op_valid), .op_kind(op_kind),
    .op_faddr(op_faddr), .op_access(op_access), .op_wdata(op_wdata),
    .op_literal(op_literal), .op_src(op_src), .op_dst(op_dst));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (bad_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  // ==========================================================
  // Single-word AHB-Lite transfer
  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  // ==========================================================
  // One decoder operation against the reference model
  task automatic op(input logic [1:0] k, input logic a);
    logic ok, miss;
    logic [7:0] d, e;
    logic [11:0] ea;
    d = 8'($urandom);
    ea = a ? {bs, f} : (f < 8'h60 ? {4'h0, f} : {4'hf, f});
    if (k == 2'h3)
      ea = t;
    miss = !MASK[ea[11:8]];
    i_op_decoder.issue(k, a, f, d, s, t, ok);
    check({31'h0, ok}, 32'h1);
    if (k == 2'h0 && (miss || mem.exists(ea)))
    begin
      e = miss ? 8'h00 : 8'(mem[ea]);
      check(op_rdata, e);
      check({flag_zero, flag_neg}, {e == 8'h00, e[7]});
    end
    if (k == 2'h1)
    begin
      if (!miss)
        mem[ea] = d;
      check({flag_zero, flag_neg}, {d == 8'h00, d[7]});
    end
    if (k == 2'h3 && !miss)
    begin
      if (!MASK[s[11:8]])
        mem[t] = 0;
      else if (mem.exists(s))
        mem[t] = mem[s];
      else
        mem.delete(t);
    end
    if (k == 2'h2)
    begin
      bs = d[3:0];
      bus(1'b0, bank_addr_pkg::BANK_SEL_OFF, 32'h0, rd);
      check(rd, {28'h0, bs});
    end
    else
    begin
      e = {7'h0, ea[11:8] == 4'hf && ea[7:0] >= 8'h60};
      check({high_area_hit, bank_missing}, {e[0], miss});
      bus(1'b0, bank_addr_pkg::STATUS_OFF, 32'h0, rd);
      check(rd[14:0], {1'b0, e[0], miss, ea});
    end
  endtask

  initial
  begin
    rd = $urandom(32'hce94);
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, bank_addr_pkg::BANK_SEL_OFF, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b1, bank_addr_pkg::BANK_SEL_OFF, 32'hfffffff5, rd);
    bus(1'b0, bank_addr_pkg::BANK_SEL_OFF, 32'h0, rd);
    check(rd, 32'h5);
    bs = 4'h5;
    bus(1'b0, 8'h40, 32'h0, rd);
    check(rd, 32'h0);
    check({31'h0, hresp}, 32'h0);
    // Addresses cluster at the window split so reads find earlier writes.
    for (int i = 0; i < 400; i++)
    begin
      f = 8'h5c + 8'($urandom % 8);
      if ($urandom % 8 == 0)
        f = 8'($urandom);
      s = {4'($urandom), 8'h5c + 8'($urandom % 8)};
      t = {4'($urandom), 8'h5c + 8'($urandom % 8)};
      op(2'($urandom), 1'($urandom));
    end
    report_and_stop();
  end
endmodule

`default_nettype wire
